// ---- common/reset_cause_pkg.sv ----
// Constants, types and helpers for the reset cause status bank
package reset_cause_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CAUSE_W = 10;
    localparam int CLOCK_HZ = 20_000_000;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses; aliases sit at base + 0x4, 0x8, 0xc
    localparam logic [15:0] TRIGGER_BASE = 16'he610;
    localparam logic [15:0] CAUSE_BASE = 16'hf600;
    localparam logic [15:0] IRQ_ENABLE_BASE = 16'hf640;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'hf650;
    localparam logic [15:0] IRQ_CLEAR_ADDR = 16'hf654;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the cause and trigger registers
    localparam int CFG_MISMATCH_BIT = 9;
    localparam int KEEP_ON_BIT = 8;
    localparam int PIN_RESET_BIT = 7;
    localparam int SOFT_RESET_BIT = 6;
    localparam int WATCHDOG_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int IDLE_BIT = 2;
    localparam int BROWNOUT_BIT = 1;
    localparam int POWERON_BIT = 0;
    localparam int SOFT_REQ_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Masks and values after reset
    localparam logic [9:0] CAUSE_WRITE_MASK = 10'h3df;
    localparam logic [9:0] CAUSE_EVENT_MASK = 10'h2df;
    localparam logic [9:0] CAUSE_RESET = 10'h003;
    localparam logic [9:0] IRQ_ENABLE_RESET = 10'h000;
    localparam logic TRIGGER_RESET = 1'b0;
    localparam logic PIN_IDLE_LEVEL = 1'b1;

    typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} alias_op_t;

    ////////////////////////////////////////////////////////////////////////
    // Alias operation from the word offset inside a register's slot
    function automatic alias_op_t op_of(input logic [15:0] addr);
        op_of = alias_op_t'(addr[3:2]);
    endfunction

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage

// ---- rtl/alias_apply.sv ----
// Write, clear, set or invert update of one register
`timescale 1ns/1ps
module alias_apply #(
    parameter int W = 10
) (
    input reset_cause_pkg::alias_op_t i_op,
    input wire logic [W-1:0] i_old,
    input wire logic [W-1:0] i_data,
    input wire logic [W-1:0] i_lanes,
    output logic [W-1:0] o_new
);
    import reset_cause_pkg::*;

    wire [W-1:0] data_in_lanes = i_data & i_lanes;
    wire [W-1:0] plain = (i_old & ~i_lanes) | data_in_lanes;

    // Unstrobed lanes keep their value for every operation
    assign o_new = (i_op == OP_CLR) ? (i_old & ~data_in_lanes) :
                   (i_op == OP_SET) ? (i_old | data_in_lanes) :
                   (i_op == OP_INV) ? (i_old ^ data_in_lanes) :
                   plain;
endmodule

// ---- rtl/pin_sync3.sv ----
// Three-stage synchroniser with agreement filter for a pin
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic IDLE = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // Level changes only once stages two and three agree
    wire agree = (s2_q == s3_q);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
            level_q <= IDLE;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                level_q <= s3_q;
        end
    end

    assign o_level = level_q;
endmodule

// ---- rtl/reset_cause_status_bank.sv ----
// Reset cause status bank with APB slave and cause interrupt
`timescale 1ns/1ps
module reset_cause_status_bank (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [reset_cause_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [reset_cause_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [reset_cause_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cfg_mismatch_evt,
    input wire logic i_master_clear_pin_n,
    input wire logic i_soft_reset_done,
    input wire logic i_watchdog_expiry_evt,
    input wire logic i_sleep_wake_evt,
    input wire logic i_idle_wake_evt,
    input wire logic i_brownout_evt,
    input wire logic i_poweron_evt,
    output logic o_regulator_standby_keep_on,
    output logic o_soft_reset_request,
    output logic o_irq
);
    import reset_cause_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic [9:0] cause_q;
    logic [9:0] cause_d;
    logic [9:0] irq_en_q;
    logic [9:0] irq_en_d;
    logic [9:0] irq_stat_q;
    logic [9:0] irq_stat_d;
    logic trig_q;
    logic trig_d;
    logic req_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic pin_level;
    logic pin_level_q;
    logic [9:0] cause_sw;
    logic [9:0] irq_en_sw;
    logic trig_sw;

    alias_op_t op;
    assign op = op_of(i_paddr);

    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    wire do_write = access & i_pwrite;
    wire aligned = (i_paddr[1:0] == 2'b00);
    wire [11:0] slot = i_paddr[15:4];
    wire hit_cause = aligned & (slot == CAUSE_BASE[15:4]);
    wire hit_trig = aligned & (slot == TRIGGER_BASE[15:4]);
    wire hit_en = aligned & (slot == IRQ_ENABLE_BASE[15:4]);
    wire hit_stat = aligned & (i_paddr == IRQ_STATUS_ADDR);
    wire hit_clr = aligned & (i_paddr == IRQ_CLEAR_ADDR);
    wire mapped = hit_cause | hit_trig | hit_en | hit_stat | hit_clr;
    wire [31:0] lanes = lane_mask(i_pstrb);

    wire wr_cause = do_write & hit_cause;
    wire wr_trig = do_write & hit_trig;
    wire wr_en = do_write & hit_en;
    wire wr_clr = do_write & hit_clr;

    ////////////////////////////////////////////////////////////////////////
    // Cause events
    pin_sync3 #(
        .IDLE(PIN_IDLE_LEVEL)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(i_master_clear_pin_n),
        .o_level(pin_level)
    );

    // Active-low pin asserted
    wire pin_fall = pin_level_q & ~pin_level;

    wire [9:0] hw_set_raw = {i_cfg_mismatch_evt, 1'b0, pin_fall,
        i_soft_reset_done, 1'b0, i_watchdog_expiry_evt, i_sleep_wake_evt,
        i_idle_wake_evt, i_brownout_evt, i_poweron_evt};
    wire [9:0] hw_set = hw_set_raw & CAUSE_EVENT_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Cause register
    alias_apply #(
        .W(CAUSE_W)
    ) u_cause_alias (
        .i_op(op),
        .i_old(cause_q),
        .i_data(i_pwdata[9:0]),
        .i_lanes(lanes[9:0]),
        .o_new(cause_sw)
    );

    // Software result first, hardware set wins over any clear
    wire [9:0] cause_wr = (cause_sw & CAUSE_WRITE_MASK)
        | (cause_q & ~CAUSE_WRITE_MASK);
    assign cause_d = (wr_cause ? cause_wr : cause_q) | hw_set;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cause_q <= CAUSE_RESET;
            pin_level_q <= PIN_IDLE_LEVEL;
        end
        else
        begin
            cause_q <= cause_d;
            pin_level_q <= pin_level;
        end
    end

    assign o_regulator_standby_keep_on = cause_q[KEEP_ON_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Software reset trigger
    alias_apply #(
        .W(1)
    ) u_trig_alias (
        .i_op(op),
        .i_old(trig_q),
        .i_data(i_pwdata[SOFT_REQ_BIT]),
        .i_lanes(lanes[SOFT_REQ_BIT]),
        .o_new(trig_sw)
    );

    // Bit drops once the resulting reset has been carried out
    assign trig_d = wr_trig ? trig_sw : (trig_q & ~i_soft_reset_done);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            trig_q <= TRIGGER_RESET;
            req_q <= 1'b0;
        end
        else
        begin
            trig_q <= trig_d;
            req_q <= trig_d & ~trig_q;
        end
    end

    assign o_soft_reset_request = req_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear
    alias_apply #(
        .W(CAUSE_W)
    ) u_en_alias (
        .i_op(op),
        .i_old(irq_en_q),
        .i_data(i_pwdata[9:0]),
        .i_lanes(lanes[9:0]),
        .o_new(irq_en_sw)
    );

    wire [9:0] clr_bits = wr_clr ? (i_pwdata[9:0] & lanes[9:0]) : 10'h000;
    assign irq_en_d = wr_en ? (irq_en_sw & CAUSE_EVENT_MASK) : irq_en_q;
    assign irq_stat_d = (irq_stat_q & ~clr_bits) | hw_set;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_en_q <= IRQ_ENABLE_RESET;
            irq_stat_q <= 10'h000;
        end
        else
        begin
            irq_en_q <= irq_en_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    assign o_irq = |(irq_stat_q & irq_en_q);

    ////////////////////////////////////////////////////////////////////////
    // Read path, sampled in the setup cycle
    wire [31:0] rd_word = hit_cause ? {22'h000000, cause_q} :
                          hit_trig ? {31'h00000000, trig_q} :
                          hit_en ? {22'h000000, irq_en_q} :
                          hit_stat ? {22'h000000, irq_stat_q} :
                          32'h00000000;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q <= i_pwrite ? 32'h00000000 : rd_word;
            err_q <= ~mapped;
        end
    end

    assign o_prdata = rdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = access & err_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_read_cause;
        setup && !i_pwrite && hit_cause ##1 access;
    endsequence

    sequence s_trig_rise;
        wr_trig && !trig_q && trig_sw;
    endsequence

    a_alias_clear: assert property (
        wr_cause && op == OP_CLR && hw_set == 10'h000 && i_pstrb == 4'hf
        |=> cause_q == ($past(cause_q) & ~($past(i_pwdata[9:0])
            & CAUSE_WRITE_MASK)))
        else $error("clear alias did not clear selected bits");

    a_mismatch_flag: assert property (
        i_cfg_mismatch_evt |=> cause_q[CFG_MISMATCH_BIT])
        else $error("mismatch event did not set its flag");

    a_keep_on_set: assert property (
        wr_cause && op == OP_SET && i_pstrb[1] && i_pwdata[KEEP_ON_BIT]
        |=> o_regulator_standby_keep_on [*2])
        else $error("regulator keep-on did not follow set alias");

    a_pin_flag: assert property (
        $fell(pin_level) |=> cause_q[PIN_RESET_BIT])
        else $error("pin reset did not set its flag");

    a_soft_flag: assert property (
        i_soft_reset_done && !wr_trig |=> cause_q[SOFT_RESET_BIT] && !trig_q)
        else $error("software reset done not recorded");

    a_watchdog_flag: assert property (
        i_watchdog_expiry_evt |=> cause_q[WATCHDOG_BIT])
        else $error("watchdog expiry did not set its flag");

    a_sleep_flag: assert property (
        i_sleep_wake_evt |=> cause_q[SLEEP_BIT])
        else $error("sleep wake did not set its flag");

    a_idle_flag: assert property (
        i_idle_wake_evt |=> cause_q[IDLE_BIT])
        else $error("idle wake did not set its flag");

    a_brownout_flag: assert property (
        i_brownout_evt |=> cause_q[BROWNOUT_BIT])
        else $error("brown-out did not set its flag");

    a_poweron_flag: assert property (
        i_poweron_evt |=> cause_q[POWERON_BIT])
        else $error("power-on did not set its flag");

    a_reserved_zero: assert property (
        s_read_cause |-> o_prdata[31:10] == 22'h000000 && !o_prdata[5])
        else $error("reserved cause bits read nonzero");

    a_trigger_pulse: assert property (
        s_trig_rise |=> o_soft_reset_request ##1 !o_soft_reset_request)
        else $error("software reset request not a single pulse");

    a_flags_sticky: assert property (
        $fell(cause_q[POWERON_BIT]) || $fell(cause_q[WATCHDOG_BIT])
        |-> $past(wr_cause))
        else $error("cause flag cleared without a write");

    a_irq_level: assert property (
        $rose(irq_stat_q[WATCHDOG_BIT]) && irq_en_q[WATCHDOG_BIT]
        |-> o_irq)
        else $error("enabled status bit did not raise interrupt");

    sequence s_unmapped;
        setup && !mapped ##1 access;
    endsequence

    a_unmapped_error: assert property (
        s_unmapped |-> o_pslverr)
        else $error("unmapped access did not flag an error");

    a_alias_invert: assert property (
        wr_cause && op == OP_INV && hw_set == 10'h000 && i_pstrb == 4'hf
        |=> cause_q == ($past(cause_q) ^ ($past(i_pwdata[9:0])
            & CAUSE_WRITE_MASK)))
        else $error("invert alias did not invert selected bits");

    a_read_cause_data: assert property (
        setup && !i_pwrite && hit_cause
        |=> o_prdata == {22'h000000, $past(cause_q)})
        else $error("cause read data differs from register");

    a_trig_set_alias: assert property (
        wr_trig && op == OP_SET && i_pstrb[0] && i_pwdata[SOFT_REQ_BIT]
        |=> trig_q)
        else $error("set alias did not raise the trigger bit");

    a_keep_on_hold: assert property (
        !wr_cause |=> $stable(cause_q[KEEP_ON_BIT]))
        else $error("regulator keep-on changed without a write");

    a_request_from_rise: assert property (
        o_soft_reset_request |-> $rose(trig_q))
        else $error("request pulse without a trigger rise");

    a_set_over_clear: assert property (
        hw_set != 10'h000
        |=> (cause_q & $past(hw_set)) == $past(hw_set))
        else $error("hardware cause set was lost");

    a_status_watchdog: assert property (
        i_watchdog_expiry_evt |=> irq_stat_q[WATCHDOG_BIT])
        else $error("watchdog expiry did not set its status bit");

    a_irq_clear: assert property (
        wr_clr |=> (irq_stat_q & $past(clr_bits & ~hw_set)) == 10'h000)
        else $error("status clear left selected bits set");
endmodule

// ---- verif/reset_cause_status_bank_bench.sv ----
// Self-checking bench for the reset cause status bank
`timescale 1ns/1ps
module reset_cause_status_bank_bench;
    import reset_cause_pkg::*;

    logic clock;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] ev;
    logic pin_n;
    logic keep_on;
    logic req;
    logic irq;
    logic [31:0] rdata;
    logic err;
    logic [31:0] expv;
    int bad_count;
    int n_checks;
    int bits[7] = '{9, 6, 4, 3, 2, 1, 0};

    reset_cause_status_bank reset_cause_status_bank_i (
        .i_clock(clock),
        .i_rst_n(rst_n),
        .i_psel(psel),
        .i_penable(penable),
        .i_pwrite(pwrite),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .i_pstrb(pstrb),
        .o_prdata(prdata),
        .o_pready(pready),
        .o_pslverr(pslverr),
        .i_cfg_mismatch_evt(ev[9]),
        .i_master_clear_pin_n(pin_n),
        .i_soft_reset_done(ev[6]),
        .i_watchdog_expiry_evt(ev[4]),
        .i_sleep_wake_evt(ev[3]),
        .i_idle_wake_evt(ev[2]),
        .i_brownout_evt(ev[1]),
        .i_poweron_evt(ev[0]),
        .o_regulator_standby_keep_on(keep_on),
        .o_soft_reset_request(req),
        .o_irq(irq)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        n = 1;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the landed write settle before callers look at outputs
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [15:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int b);
        @(posedge clock);
        ev[b] <= 1'b1;
        @(posedge clock);
        ev[b] <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ev = 10'h0;
        pin_n = 1'b1;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(CAUSE_BASE);
        check("cause reset", rdata, 32'h3);
        rd(TRIGGER_BASE);
        check("trigger reset", rdata, 32'h0);
        check("keep on reset", {31'h0, keep_on}, 32'h0);
        check("irq reset", {31'h0, irq}, 32'h0);
        $display("test reset values done");

        wr(CAUSE_BASE + 16'h4, 32'h3);
        rd(CAUSE_BASE);
        check("cause clr alias", rdata, 32'h0);
        wr(CAUSE_BASE + 16'h8, 32'h100);
        check("keep on set", {31'h0, keep_on}, 32'h1);
        rd(CAUSE_BASE);
        check("cause set alias", rdata, 32'h100);
        wr(CAUSE_BASE + 16'hc, 32'h101);
        rd(CAUSE_BASE);
        check("cause inv alias", rdata, 32'h1);
        check("keep on cleared", {31'h0, keep_on}, 32'h0);
        wr(CAUSE_BASE, 32'hffff_ffff);
        rd(CAUSE_BASE);
        check("cause all ones", rdata, 32'h3df);
        wr(CAUSE_BASE, 32'h0);
        rd(CAUSE_BASE);
        check("cause written zero", rdata, 32'h0);
        $display("test aliases done");

        expv = 32'h0;
        foreach (bits[i])
        begin
            pulse(bits[i]);
            expv[bits[i]] = 1'b1;
            rd(CAUSE_BASE);
            check("cause event", rdata, expv);
        end
        @(posedge clock);
        pin_n <= 1'b0;
        repeat (8) @(posedge clock);
        pin_n <= 1'b1;
        repeat (6) @(posedge clock);
        rd(CAUSE_BASE);
        check("cause pin reset", rdata, expv | 32'h80);
        $display("test events done");

        wr(TRIGGER_BASE + 16'h8, 32'h1);
        #1 check("request pulse", {31'h0, req}, 32'h1);
        @(posedge clock);
        #1 check("request ends", {31'h0, req}, 32'h0);
        rd(TRIGGER_BASE);
        check("trigger set", rdata, 32'h1);
        wr(CAUSE_BASE + 16'h4, 32'h3ff);
        pulse(6);
        rd(TRIGGER_BASE);
        check("trigger done", rdata, 32'h0);
        rd(CAUSE_BASE);
        check("soft reset flag", rdata, 32'h40);
        $display("test soft reset done");

        wr(TRIGGER_BASE + 16'h8, 32'h1);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(TRIGGER_BASE);
        check("trigger after reset", rdata, 32'h0);
        rd(CAUSE_BASE);
        check("cause after reset", rdata, 32'h3);
        check("keep on after reset", {31'h0, keep_on}, 32'h0);
        $display("test mid-run reset done");

        wr(IRQ_CLEAR_ADDR, 32'hffff_ffff);
        wr(IRQ_ENABLE_BASE, 32'h10);
        pulse(4);
        #1 check("irq raised", {31'h0, irq}, 32'h1);
        rd(IRQ_STATUS_ADDR);
        check("irq status", rdata, 32'h10);
        wr(IRQ_ENABLE_BASE + 16'h4, 32'h10);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(IRQ_ENABLE_BASE + 16'h8, 32'h10);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(IRQ_CLEAR_ADDR, 32'h10);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd(IRQ_STATUS_ADDR);
        check("irq status clear", rdata, 32'h0);
        rd(16'hf700);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rdata, 32'h0);
        $display("test interrupt and map done");
        print_verdict();
    end
endmodule
